// >>> hdl/lfdl_top.sv
// Legacy T1 data-link byte handler with Avalon-MM registers and interrupt.
// ============================================================================
// Notes on behaviour
// R1: Received link bits shift into receive byte.
// R2: Full byte sets status, unmasked drives interrupt low.
// R3: Host reads byte within one byte period.
// R4: Byte equal to either match sets match.
// R5: Destuffer drops zero after five ones.
// R6: Zero after six or more ones kept.
// R7: Software keeps destuffer on when extracting.
// R8: Transmit byte sent low bit first.
// R9: Eight bits sent sets empty status, interrupts.
// R10: Unchanged transmit byte is simply resent.
// R11: Stuffer inserts zero after five ones.
// R12: Software keeps stuffer on when inserting.
// R13: Software loads transmit byte with D4 pattern.
// R14: Fs source select clear uses transmit byte.
// R15: Multiframe load takes byte only at boundaries.
// R16: SLC-96 fields use the same byte registers.
// R17: Matching only when a whole byte completes.
// R18: Status latched until cleared, interrupt then released.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module lfdl_top
  import lfdl_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [11:0]  avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic [31:0]       avs_readdata_o,
  output logic              avs_waitrequest_o,
  input  wire lfdl_bit_type rx_link_i,
  input  wire logic         tx_slot_i,
  input  wire logic         tx_alt_bit_i,
  input  wire logic         multiframe_i,
  output logic              tx_link_bit_o,
  output logic              link_int_n_o
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]    link_transmit_byte;
  logic [7:0]    link_match_byte_a;
  logic [7:0]    link_match_byte_b;
  logic [7:0]    link_status_reg;
  logic [7:0]    link_interrupt_mask_reg;
  logic [7:0]    t1_receive_control_two;
  logic [7:0]    t1_transmit_control_one;
  logic [7:0]    t1_transmit_control_two;
  logic [7:0]    link_receive_byte;
  logic [7:0]    next_status;
  logic [7:0]    tx_hold;
  logic [7:0]    rd_val;
  logic [9:0]    idx;
  logic          ack_q;
  logic          req;
  logic          wr_fire;
  logic          rd_fire;
  logic          st_rd_clr;
  logic          rx_done;
  logic          tx_done;
  logic          rx_match;
  lfdl_ctrl_type ctrl;

  assign idx       = avs_address_i[11:2];
  assign req       = avs_read_i || avs_write_i;
  assign wr_fire   = avs_write_i && ack_q && ce_i && avs_byteenable_i[0];
  assign rd_fire   = avs_read_i && ack_q && ce_i;
  assign st_rd_clr = rd_fire && (idx == IDX_STATUS);

  assign ctrl.destuff_en = t1_receive_control_two[RXC2_DESTUFF_BIT];
  assign ctrl.stuff_en   = t1_transmit_control_two[TXC2_STUFF_BIT];
  assign ctrl.mf_load    = t1_transmit_control_two[TXC2_MF_LOAD_BIT];
  assign ctrl.fs_ext     = t1_transmit_control_one[TXC1_FS_EXT_BIT];

  // ==========================================================================
  // Avalon-MM slave, one wait state per access
  // ==========================================================================
  // Waitrequest stays high while the clock enable is low, so a request
  // never completes on a frozen cycle.
  assign avs_waitrequest_o = req && !(ack_q && ce_i);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      IDX_RX_BYTE:  rd_val = link_receive_byte; // [R16]
      IDX_TX_BYTE:  rd_val = link_transmit_byte;
      IDX_MATCH_A:  rd_val = link_match_byte_a;
      IDX_MATCH_B:  rd_val = link_match_byte_b;
      IDX_STATUS:   rd_val = link_status_reg;
      IDX_MASK:     rd_val = link_interrupt_mask_reg;
      IDX_RX_CTRL2: rd_val = t1_receive_control_two;
      IDX_TX_CTRL1: rd_val = t1_transmit_control_one;
      IDX_TX_CTRL2: rd_val = t1_transmit_control_two;
      default:      rd_val = 8'h00;
    endcase
  end

  // Read data is captured in the wait cycle and stands at the completing edge.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && !ack_q) begin
      avs_readdata_o <= {24'h00_0000, rd_val};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_transmit_byte      <= RST_TX_BYTE;
      link_match_byte_a       <= RST_MATCH;
      link_match_byte_b       <= RST_MATCH;
      link_interrupt_mask_reg <= RST_MASK;
      t1_receive_control_two  <= RST_CTRL;
      t1_transmit_control_one <= RST_CTRL;
      t1_transmit_control_two <= RST_CTRL;
    end else if (wr_fire) begin
      unique case (idx)
        IDX_TX_BYTE:  link_transmit_byte      <= avs_writedata_i[7:0];
        IDX_MATCH_A:  link_match_byte_a       <= avs_writedata_i[7:0];
        IDX_MATCH_B:  link_match_byte_b       <= avs_writedata_i[7:0];
        IDX_MASK:     link_interrupt_mask_reg <= avs_writedata_i[7:0];
        IDX_RX_CTRL2: t1_receive_control_two  <= avs_writedata_i[7:0];
        IDX_TX_CTRL1: t1_transmit_control_one <= avs_writedata_i[7:0];
        IDX_TX_CTRL2: t1_transmit_control_two <= avs_writedata_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Receive path
  // ==========================================================================
  lfdl_rx_unstuff u_rx (
    .clk_i        (sys_clk_i),
    .rst_n_i      (rst_n),
    .ce_i         (ce_i),
    .rx_i         (rx_link_i),
    .destuff_en_i (ctrl.destuff_en),
    .byte_o       (link_receive_byte),
    .done_o       (rx_done)
  );

  // The compare looks only at a freshly completed byte.
  assign rx_match = rx_done && ((link_receive_byte == link_match_byte_a) ||
                                (link_receive_byte == link_match_byte_b)); // [R4] [R17]

  // ==========================================================================
  // Transmit path
  // ==========================================================================
  // In multiframe mode the staged copy moves only on a boundary, so a host
  // write mid-multiframe cannot tear the Fs pattern.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold <= RST_TX_BYTE;
    end else if (ce_i && (!ctrl.mf_load || multiframe_i)) begin
      tx_hold <= link_transmit_byte; // [R15] [R10]
    end
  end

  lfdl_tx_stuff u_tx (
    .clk_i       (sys_clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .slot_i      (tx_slot_i),
    .stuff_en_i  (ctrl.stuff_en),
    .fs_ext_i    (ctrl.fs_ext),
    .alt_bit_i   (tx_alt_bit_i),
    .load_byte_i (tx_hold),
    .bit_o       (tx_link_bit_o),
    .done_o      (tx_done)
  );

  // ==========================================================================
  // Status and interrupt
  // ==========================================================================
  // A status read clears only the bits it returned; an event at the same
  // edge sets its bit again.
  always_comb begin
    next_status = link_status_reg;
    if (st_rd_clr) begin
      next_status = link_status_reg & ~avs_readdata_o[7:0]; // [R18]
    end
    if (rx_done) begin
      next_status[ST_RX_FULL_BIT] = 1'b1; // [R2]
    end
    if (rx_match) begin
      next_status[ST_MATCH_BIT] = 1'b1; // [R4]
    end
    if (tx_done) begin
      next_status[ST_TX_EMPTY_BIT] = 1'b1; // [R9]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_status_reg <= RST_STATUS;
    end else if (ce_i) begin
      link_status_reg <= next_status;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_int_n_o <= 1'b1;
    end else if (ce_i) begin
      link_int_n_o <= ~|(next_status & link_interrupt_mask_reg); // [R2] [R18]
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_req_start;
    req && !ack_q && ce_i;
  endsequence

  sequence s_req_done;
    ce_i && !avs_waitrequest_o;
  endsequence

  AST_BUS_ONE_WAIT: assert property (s_req_start ##1 ce_i |-> s_req_done)
    else $error("Bus access did not finish after one wait state.");
  AST_RX_FULL_SET: assert property (ce_i && rx_done |=> link_status_reg[ST_RX_FULL_BIT]) // [R2]
    else $error("Receive full not set on completed byte.");
  AST_MATCH_SET: assert property (ce_i && rx_match |=> link_status_reg[ST_MATCH_BIT]) // [R4]
    else $error("Match status not set.");
  AST_MATCH_ONLY_ON_BYTE: assert property ($rose(link_status_reg[ST_MATCH_BIT]) // [R17]
    |-> $past(rx_done && ce_i))
    else $error("Match set without a completed byte.");
  AST_TX_EMPTY_SET: assert property (ce_i && tx_done |=> link_status_reg[ST_TX_EMPTY_BIT]) // [R9]
    else $error("Transmit empty not set after eight bits.");
  AST_INT_ASSERT: assert property (ce_i && |(next_status & link_interrupt_mask_reg) // [R2]
    |=> !link_int_n_o)
    else $error("Interrupt not driven low for unmasked status.");
  AST_INT_RELEASE: assert property (ce_i && !(|(next_status & link_interrupt_mask_reg)) // [R18]
    |=> link_int_n_o)
    else $error("Interrupt held with nothing pending.");
  AST_STATUS_HOLD: assert property (ce_i && link_status_reg[ST_RX_FULL_BIT] && !st_rd_clr // [R18]
    |=> link_status_reg[ST_RX_FULL_BIT])
    else $error("Receive full dropped without a read.");
  AST_MF_HOLD: assert property (ce_i && ctrl.mf_load && !multiframe_i |=> $stable(tx_hold)) // [R15]
    else $error("Transmit byte loaded off a multiframe boundary.");

endmodule
`default_nettype wire

// >>> common/lfdl_pkg.sv
// Shared constants, types and helpers for the legacy T1 data-link byte handler.
`default_nettype none
package lfdl_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  // ==========================================================================
  localparam logic [9:0] IDX_RX_BYTE   = 10'h0C0;
  localparam logic [9:0] IDX_TX_BYTE   = 10'h0C1;
  localparam logic [9:0] IDX_MATCH_A   = 10'h0C2;
  localparam logic [9:0] IDX_MATCH_B   = 10'h0C3;
  localparam logic [9:0] IDX_STATUS    = 10'h0C4;
  localparam logic [9:0] IDX_MASK      = 10'h0C5;
  localparam logic [9:0] IDX_RX_CTRL2  = 10'h0C6;
  localparam logic [9:0] IDX_TX_CTRL1  = 10'h0C7;
  localparam logic [9:0] IDX_TX_CTRL2  = 10'h0C8;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ST_MATCH_BIT      = 1;
  localparam int ST_TX_EMPTY_BIT   = 2;
  localparam int ST_RX_FULL_BIT    = 3;
  localparam int RXC2_DESTUFF_BIT  = 3;
  localparam int TXC1_FS_EXT_BIT   = 2;
  localparam int TXC2_STUFF_BIT    = 5;
  localparam int TXC2_MF_LOAD_BIT  = 6;

  // ==========================================================================
  // Reset values and patterns
  // ==========================================================================
  localparam logic [7:0] RST_TX_BYTE   = 8'h00;
  localparam logic [7:0] RST_MATCH     = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] RST_STATUS    = 8'h00;
  localparam logic [7:0] D4_FS_PATTERN = 8'h1C;
  localparam logic [2:0] ONES_LIMIT    = 3'h5;
  localparam logic [2:0] ONES_SAT      = 3'h6;
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic slot;
    logic data;
  } lfdl_bit_type;

  typedef struct packed {
    logic fs_ext;
    logic mf_load;
    logic stuff_en;
    logic destuff_en;
  } lfdl_ctrl_type;

  // Run length of ones, saturating so that long runs stay recognisable.
  function automatic logic [2:0] lfdl_ones_next(input logic [2:0] ones, input logic b);
    if (!b) begin
      return 3'h0;
    end
    if (ones == ONES_SAT) begin
      return ONES_SAT;
    end
    return ones + 3'h1;
  endfunction

endpackage
`default_nettype wire

// >>> hdl/lfdl_rx_unstuff.sv
// Receive link bit deserialiser with zero destuffer.
`timescale 1ns/1ns
`default_nettype none
module lfdl_rx_unstuff
  import lfdl_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire lfdl_bit_type rx_i,
  input  wire logic         destuff_en_i,
  output logic [7:0]        byte_o,
  output logic              done_o
);

  logic [7:0] shift;
  logic [2:0] cnt;
  logic [2:0] ones;
  logic       drop;

  // A zero after exactly five ones is a stuffed bit; longer runs are flags.
  assign drop = destuff_en_i && !rx_i.data && (ones == ONES_LIMIT); // [R5] [R6]

  // ==========================================================================
  // Run tracking
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ones <= 3'h0;
    end else if (ce_i && rx_i.slot) begin
      ones <= lfdl_ones_next(ones, rx_i.data);
    end
  end

  // ==========================================================================
  // Shift in, first bit ends in bit 0
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift  <= 8'h00;
      cnt    <= 3'h0;
      byte_o <= 8'h00;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (rx_i.slot && !drop) begin
        shift <= {rx_i.data, shift[7:1]}; // [R1]
        cnt   <= cnt + 3'h1;
        if (cnt == LAST_BIT) begin
          byte_o <= {rx_i.data, shift[7:1]};
          done_o <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_DESTUFF_DROP: assert property (ce_i && rx_i.slot && drop |=> cnt == $past(cnt)) // [R5]
    else $error("Stuffed zero was not discarded.");
  AST_SIX_ONES_KEEP: assert property (ce_i && rx_i.slot && !rx_i.data && ones == ONES_SAT // [R6]
    |=> cnt == 3'($past(cnt) + 3'h1))
    else $error("Zero after six ones was discarded.");

endmodule
`default_nettype wire

// >>> hdl/lfdl_tx_stuff.sv
// Transmit link bit serialiser with zero stuffer.
`timescale 1ns/1ns
`default_nettype none
module lfdl_tx_stuff
  import lfdl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       slot_i,
  input  wire logic       stuff_en_i,
  input  wire logic       fs_ext_i,
  input  wire logic       alt_bit_i,
  input  wire logic [7:0] load_byte_i,
  output logic            bit_o,
  output logic            done_o
);

  logic [7:0] shift;
  logic [2:0] cnt;
  logic [2:0] ones;
  logic       stuff;
  logic       cur;

  // A run can reach six while stuffing is off, so enabling it mid-run must still stuff.
  assign stuff = stuff_en_i && (ones >= ONES_LIMIT); // [R11]
  assign cur   = (cnt == 3'h0) ? load_byte_i[0] : shift[0];

  // ==========================================================================
  // Serialiser; the byte is sampled only at its first bit
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift  <= 8'h00;
      cnt    <= 3'h0;
      ones   <= 3'h0;
      bit_o  <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (slot_i && stuff) begin
        bit_o <= fs_ext_i ? alt_bit_i : 1'b0; // [R11]
        ones  <= 3'h0;
      end else if (slot_i) begin
        bit_o <= fs_ext_i ? alt_bit_i : cur; // [R8] [R14]
        ones  <= lfdl_ones_next(ones, cur);
        shift <= (cnt == 3'h0) ? {1'b0, load_byte_i[7:1]} : {1'b0, shift[7:1]};
        cnt   <= cnt + 3'h1;
        done_o <= (cnt == LAST_BIT); // [R9]
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_STUFF_ZERO: assert property (ce_i && slot_i && stuff && !fs_ext_i |=> !bit_o) // [R11]
    else $error("No zero inserted after five ones.");
  AST_TX_LSB_FIRST: assert property (ce_i && slot_i && !stuff && !fs_ext_i && cnt == 3'h0 // [R8]
    |=> bit_o == $past(load_byte_i[0]))
    else $error("Byte did not start with its low bit.");

endmodule
`default_nettype wire

// >>> dv/lfdl_far_model.sv
// Framer-side model that supplies received link bits and pulls transmit link bits.
`timescale 1ns/1ns
`default_nettype none
module lfdl_far_model
  import lfdl_pkg::*;
(
  input  wire logic        clk_i,
  output var lfdl_bit_type rx_link_o,
  output logic             tx_slot_o,
  output logic             alt_bit_o,
  output logic             mf_o
);
  // ==========================================================================
  // Slot timing
  // ==========================================================================
  initial begin
    rx_link_o = 2'h0;
    tx_slot_o = 1'b0;
    alt_bit_o = 1'b0;
    mf_o      = 1'b0;
  end

  // Between slots the data line flips each cycle, so a stale bit never passes for data.
  task automatic send_bit(input logic b, input int gap);
    repeat (gap) begin
      @(posedge clk_i);
      rx_link_o <= {1'b0, ~rx_link_o.data};
    end
    @(posedge clk_i);
    rx_link_o <= {1'b1, b};
    @(posedge clk_i);
    rx_link_o <= {1'b0, ~b};
  endtask

  task automatic pull_bit(input logic alt, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    tx_slot_o <= 1'b1;
    alt_bit_o <= alt;
    @(posedge clk_i);
    tx_slot_o <= 1'b0;
    alt_bit_o <= ~alt;
  endtask

  task automatic frame_mark();
    @(posedge clk_i);
    mf_o <= 1'b1;
    @(posedge clk_i);
    mf_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/lfdl_top_tb.sv
// Self-checking bench for the legacy T1 data-link byte handler.
`timescale 1ns/1ns
`default_nettype none
module lfdl_top_tb
  import lfdl_pkg::*;
;
  logic         sys_clk_i      = 1'b0;
  logic         ce             = 1'b1;
  logic         nrst_i         = 1'b0;
  logic         avs_read       = 1'b0;
  logic         avs_write      = 1'b0;
  logic [11:0]  avs_address    = 12'h000;
  logic [31:0]  avs_writedata  = 32'h0;
  logic [3:0]   avs_byteenable = 4'hF;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  lfdl_bit_type rx_link;
  logic         tx_slot;
  logic         alt_bit;
  logic         mf;
  logic         tx_bit;
  logic         int_n;
  logic         tx_seen        = 1'b0;
  logic [7:0]   exp_rd[$];
  logic         exp_tx[$];
  int           n_errors       = 0;
  int           checks         = 0;
  logic [7:0]   ma;
  logic [7:0]   tb;
  logic [7:0]   alts;

  always #20 sys_clk_i = ~sys_clk_i;

  lfdl_top DUT (
    .sys_clk_i         (sys_clk_i),
    .nrst_i            (nrst_i),
    .ce_i              (ce),
    .avs_address_i     (avs_address),
    .avs_read_i        (avs_read),
    .avs_write_i       (avs_write),
    .avs_writedata_i   (avs_writedata),
    .avs_byteenable_i  (avs_byteenable),
    .avs_readdata_o    (avs_readdata),
    .avs_waitrequest_o (avs_waitrequest),
    .rx_link_i         (rx_link),
    .tx_slot_i         (tx_slot),
    .tx_alt_bit_i      (alt_bit),
    .multiframe_i      (mf),
    .tx_link_bit_o     (tx_bit),
    .link_int_n_o      (int_n)
  );

  lfdl_far_model u_far (
    .clk_i     (sys_clk_i),
    .rx_link_o (rx_link),
    .tx_slot_o (tx_slot),
    .alt_bit_o (alt_bit),
    .mf_o      (mf)
  );

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    tx_seen <= tx_slot;
    if (tx_seen) begin
      check({31'h0, tx_bit}, {31'h0, exp_tx.pop_front()});
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      check(avs_readdata, {24'h0, exp_rd.pop_front()});
    end
  end

  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] b);
    int   n;
    logic ok;
    n = 0;
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= b;
    avs_read       <= ~w;
    avs_write      <= w;
    do begin
      @(negedge sys_clk_i);
      ok = (avs_waitrequest === 1'b0);
      n++;
      @(posedge sys_clk_i);
    end while (!ok && n < 20);
    if (!ok) begin
      n_errors++;
      $display("[FAIL] %0t bus request never answered", $time);
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(1'b0, idx, 8'h00, 4'hF);
  endtask

  // Status is read only once the line side is quiet, since an event on the read edge would win.
  task automatic rx_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) u_far.send_bit(v[i], i % 3);
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic tx_bits(input logic [15:0] v, input logic [7:0] alt, input int n);
    for (int i = 0; i < n; i++) begin
      exp_tx.push_back(v[i]);
      u_far.pull_bit(alt[i % 8], i % 2);
    end
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic int_is(input logic v);
    repeat (3) @(posedge sys_clk_i);
    check({31'h0, int_n}, {31'h0, v});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    void'($urandom(32'h4198B5B3));
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 9; i++) rd(IDX_RX_BYTE + 10'(i), 8'h00);
    rd(10'h000, 8'h00);
    wr(IDX_RX_BYTE, 8'h5A);
    rd(IDX_RX_BYTE, 8'h00);
    wr(IDX_STATUS, 8'h0E);
    rd(IDX_STATUS, 8'h00);
    $display("test registers done");
    ma = 8'hC1 | 8'($urandom & 32'h3E);
    wr(IDX_MATCH_A, ma);
    wr(IDX_MATCH_B, 8'h55);
    bus(1'b1, IDX_MATCH_A, 8'h00, 4'h0);
    rd(IDX_MATCH_A, ma);
    rx_bits(16'h00AA, 8);
    rx_bits(16'h00AA, 8);
    int_is(1'b1);
    wr(IDX_MASK, 8'h0E);
    int_is(1'b0);
    rd(IDX_RX_BYTE, 8'hAA);
    rd(IDX_STATUS, 8'h08);
    int_is(1'b1);
    rx_bits({8'h00, ma}, 8);
    rx_bits(16'h0055, 8);
    rd(IDX_STATUS, 8'h0A);
    rd(IDX_RX_BYTE, 8'h55);
    $display("test receive done");
    wr(IDX_RX_CTRL2, 8'h08);
    rx_bits(16'h01BE, 9);
    rd(IDX_RX_BYTE, 8'hFE);
    rx_bits(16'h007E, 8);
    rd(IDX_RX_BYTE, 8'h7E);
    rd(IDX_STATUS, 8'h08);
    $display("test destuff done");
    // Bit 7 is kept clear so every pass ends a run of ones before the stuffer is enabled.
    tb = 8'($urandom) & 8'h7F;
    wr(IDX_TX_BYTE, tb);
    tx_bits({8'h00, tb}, 8'h00, 8);
    int_is(1'b0);
    rd(IDX_STATUS, 8'h04);
    tx_bits({8'h00, tb}, 8'h00, 8);
    rd(IDX_STATUS, 8'h04);
    alts = 8'($urandom) & 8'h7F;
    wr(IDX_TX_CTRL1, 8'h04);
    tx_bits({8'h00, alts}, alts, 8);
    wr(IDX_TX_CTRL1, 8'h00);
    rd(IDX_STATUS, 8'h04);
    $display("test transmit done");
    wr(IDX_TX_CTRL2, 8'h20);
    wr(IDX_TX_BYTE, 8'hFF);
    tx_bits(16'h01DF, 8'hFF, 9);
    rd(IDX_STATUS, 8'h04);
    wr(IDX_TX_CTRL2, 8'h40);
    wr(IDX_TX_BYTE, D4_FS_PATTERN);
    tx_bits(16'h00FF, 8'h00, 8);
    u_far.frame_mark();
    tx_bits({8'h00, D4_FS_PATTERN}, 8'h00, 8);
    rd(IDX_TX_BYTE, D4_FS_PATTERN);
    rd(IDX_STATUS, 8'h04);
    int_is(1'b1);
    ce <= 1'b0;
    rx_bits(16'h00C3, 8);
    ce <= 1'b1;
    rd(IDX_RX_BYTE, 8'h7E);
    rd(IDX_STATUS, 8'h00);
    $display("test stuff and multiframe done");
    stop_test();
  end
endmodule
`default_nettype wire
